/* gpde_pkg.sv */
/*
 * gpde_pkg: register map, reset values, field positions and state
 * types for the port D (pins 6/7) and port E pin logic.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
package gpde_pkg;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] GPDE_OFS_PD_DIR  = 8'h00;
	localparam logic [7:0] GPDE_OFS_PD_LAT  = 8'h04;
	localparam logic [7:0] GPDE_OFS_PD_PIN  = 8'h08;
	localparam logic [7:0] GPDE_OFS_PD_ANS  = 8'h0C;
	localparam logic [7:0] GPDE_OFS_PE_DIR  = 8'h10;
	localparam logic [7:0] GPDE_OFS_PE_LAT  = 8'h14;
	localparam logic [7:0] GPDE_OFS_PE_PIN  = 8'h18;
	localparam logic [7:0] GPDE_OFS_PE_ANS  = 8'h1C;
	localparam logic [7:0] GPDE_OFS_SLEW    = 8'h20;
	localparam logic [7:0] GPDE_OFS_CFG3H   = 8'h24;

	// ****************************************************************
	// reset values and field layout
	// ****************************************************************
	localparam logic [7:0] GPDE_RST_PD_DIR  = 8'hFF;
	localparam logic [7:0] GPDE_RST_PD_LAT  = 8'h00;
	localparam logic [7:0] GPDE_RST_PD_ANS  = 8'hFF;
	localparam logic [2:0] GPDE_RST_PE_DIR  = 3'h7;
	localparam logic [2:0] GPDE_RST_PE_LAT  = 3'h0;
	localparam logic [2:0] GPDE_RST_PE_ANS  = 3'h7;
	localparam logic [4:0] GPDE_RST_SLEW    = 5'h1F;
	localparam logic [7:0] GPDE_RST_CFG3H   = 8'hBF;
	localparam logic [7:0] GPDE_CFG3H_MASK  = 8'hBF;
	localparam int unsigned GPDE_CFG_RST_PIN   = 7;
	localparam int unsigned GPDE_CFG_PWM2B_MAP = 5;
	localparam int unsigned GPDE_CFG_T3CK_MAP  = 4;
	localparam int unsigned GPDE_CFG_CC3_MAP   = 2;
	localparam int unsigned GPDE_CFG_CC2_MAP   = 0;
	localparam int unsigned GPDE_PD_SIX        = 6;
	localparam int unsigned GPDE_PD_SEVEN      = 7;

	// ****************************************************************
	// state types
	// ****************************************************************
	typedef enum logic [1:0] {
		GPDE_APB_IDLE = 2'b01,
		GPDE_APB_ACK  = 2'b10
	} gpde_apb_state_type;

	typedef struct packed {
		logic [7:0] pd_dir;
		logic [7:0] pd_lat;
		logic [7:0] pd_ans;
		logic [2:0] pe_dir;
		logic [2:0] pe_lat;
		logic [2:0] pe_ans;
		logic [4:0] slew;
		logic [7:0] cfg;
	} gpde_regs_type;

	typedef struct packed {
		logic [1:0] pd_out;
		logic [1:0] pd_oe;
		logic [2:0] pe_out;
		logic [2:0] pe_oe;
		logic       ext_rst_n;
		logic       ser_rx;
		logic       ser_clk;
	} gpde_pads_type;

	typedef struct packed {
		gpde_apb_state_type apb;
		logic [31:0]        prdata;
		logic               pslverr;
	} gpde_bus_type;

	typedef struct packed {
		gpde_regs_type regs;
		gpde_pads_type pads;
		gpde_bus_type  bus;
	} gpde_state_type;

	localparam gpde_state_type GPDE_STATE_RST = '{
		regs: '{pd_dir: GPDE_RST_PD_DIR, pd_lat: GPDE_RST_PD_LAT, pd_ans: GPDE_RST_PD_ANS,
			pe_dir: GPDE_RST_PE_DIR, pe_lat: GPDE_RST_PE_LAT, pe_ans: GPDE_RST_PE_ANS,
			slew: GPDE_RST_SLEW, cfg: GPDE_RST_CFG3H},
		pads: '{pd_out: 2'h0, pd_oe: 2'h0, pe_out: 3'h0, pe_oe: 3'h0,
			ext_rst_n: 1'b1, ser_rx: 1'b0, ser_clk: 1'b0},
		bus:  '{apb: GPDE_APB_IDLE, prdata: 32'h0, pslverr: 1'b0}
	};

	// address match, shared by the read mux and the write path
	function automatic logic gpde_hit(input logic [7:0] addr, input logic [7:0] ofs);
		gpde_hit = (addr == ofs);
	endfunction : gpde_hit

	function automatic logic gpde_mapped(input logic [7:0] addr);
		gpde_mapped = (addr[1:0] == 2'h0) && (addr <= GPDE_OFS_CFG3H);
	endfunction : gpde_mapped

endpackage : gpde_pkg

/* gpde_sync.sv */
/*
 * gpde_sync: two-flop synchroniser for pad levels, one bit per lane.
 * Assumes the inputs are asynchronous to clk; only stage two is read.
 */
`timescale 1ns/1ns
module gpde_sync
	import gpde_pkg::*;
#(
	parameter int unsigned W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpde_sync_state_type;

	gpde_sync_state_type st_ff;
	gpde_sync_state_type nxt_st;

	// stage one feeds only stage two
	always_comb begin
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// start high: the reset pin idles high, so release gives no false reset pulse
			st_ff <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;

endmodule : gpde_sync

/* gpde_top.sv */
/*
 * gpde_top: pin logic for port D pins 6/7 and the 4-bit port E, with
 * APB register access, peripheral pin takeover and analog masking.
 * Assumes pad levels are asynchronous, peripheral controls come from
 * logic on REF_CLK, and the pad wire is resolved from the enables.
 */
`timescale 1ns/1ns
module gpde_top
	import gpde_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [1:0]  PD_PIN_IN,
	output logic      [1:0]  PD_PIN_OUT,
	output logic      [1:0]  PD_PIN_OE,
	input  wire logic [3:0]  PE_PIN_IN,
	output logic      [2:0]  PE_PIN_OUT,
	output logic      [2:0]  PE_PIN_OE,
	input  wire logic        PWM1_OUTPUT_C_EN,
	input  wire logic        PWM1_OUTPUT_C,
	input  wire logic        PWM1_OUTPUT_D_EN,
	input  wire logic        PWM1_OUTPUT_D,
	input  wire logic        SERIAL2_EN,
	input  wire logic        SERIAL2_SYNC_MODE,
	input  wire logic        SERIAL2_ASYNC_TX,
	input  wire logic        SERIAL2_SYNC_CLOCK_OUT,
	input  wire logic        SERIAL2_SYNC_CLOCK_DRIVE,
	input  wire logic        SERIAL2_SYNC_DATA_OUT,
	input  wire logic        SERIAL2_SYNC_DATA_DRIVE,
	output logic             SERIAL2_RX_DATA_IN,
	output logic             SERIAL2_SYNC_CLOCK_IN,
	output logic             EXTERNAL_RESET_IN_N,
	output logic      [1:0]  ANALOG_SEL_D,
	output logic      [2:0]  ANALOG_SEL_E,
	output logic      [4:0]  SLEW_CTRL,
	output logic      [3:0]  PIN_MAP_CFG
);

	// ****************************************************************
	// pad input synchronisers
	// ****************************************************************
	logic [1:0]     pd_sync;
	logic [3:0]     pe_sync;
	gpde_state_type st_ff;
	gpde_state_type nxt_st;
	logic [7:0]     pd_level;
	logic [3:0]     pe_level;
	logic [31:0]    rd_word;

	// one synchroniser for all six pad inputs keeps their skew equal
	gpde_sync #(.W(6)) u_sync (
		.clk   (REF_CLK),
		.rst_n (RESET_N),
		.d     ({PD_PIN_IN, PE_PIN_IN}),
		.q     ({pd_sync, pe_sync})
	);

	// ****************************************************************
	// pin-level views and read mux
	// ****************************************************************
	// analog pins read zero; the lower port D pins are not in this block
	always_comb begin
		pd_level = {pd_sync & ~st_ff.regs.pd_ans[7:6], 6'h00};
		pe_level[2:0] = pe_sync[2:0] & ~st_ff.regs.pe_ans;
		pe_level[3] = pe_sync[3] & ~st_ff.regs.cfg[GPDE_CFG_RST_PIN];
	end

	// every field is zero-extended, so unimplemented bits read zero
	always_comb begin
		rd_word = 32'h0;
		if (gpde_hit(PADDR, GPDE_OFS_PD_DIR)) rd_word[7:0] = st_ff.regs.pd_dir;
		if (gpde_hit(PADDR, GPDE_OFS_PD_LAT)) rd_word[7:0] = st_ff.regs.pd_lat;
		if (gpde_hit(PADDR, GPDE_OFS_PD_PIN)) rd_word[7:0] = pd_level;
		if (gpde_hit(PADDR, GPDE_OFS_PD_ANS)) rd_word[7:0] = st_ff.regs.pd_ans;
		if (gpde_hit(PADDR, GPDE_OFS_PE_DIR)) rd_word[2:0] = st_ff.regs.pe_dir;
		if (gpde_hit(PADDR, GPDE_OFS_PE_LAT)) rd_word[2:0] = st_ff.regs.pe_lat;
		if (gpde_hit(PADDR, GPDE_OFS_PE_PIN)) rd_word[3:0] = pe_level;
		if (gpde_hit(PADDR, GPDE_OFS_PE_ANS)) rd_word[2:0] = st_ff.regs.pe_ans;
		if (gpde_hit(PADDR, GPDE_OFS_SLEW))   rd_word[4:0] = st_ff.regs.slew;
		if (gpde_hit(PADDR, GPDE_OFS_CFG3H))  rd_word[7:0] = st_ff.regs.cfg;
	end

	// ****************************************************************
	// next state: bus slave, registers and pad control
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		// apb: one wait state, write commits on the edge that sees pready
		case (st_ff.bus.apb)
			GPDE_APB_IDLE: begin
				if (PSEL && PENABLE) begin
					nxt_st.bus.apb     = GPDE_APB_ACK;
					nxt_st.bus.prdata  = rd_word;
					nxt_st.bus.pslverr = !gpde_mapped(PADDR);
				end
			end
			GPDE_APB_ACK: begin
				nxt_st.bus.apb     = GPDE_APB_IDLE;
				nxt_st.bus.prdata  = 32'h0;
				nxt_st.bus.pslverr = 1'b0;
				if (PSEL && PENABLE && PWRITE) begin
					if (gpde_hit(PADDR, GPDE_OFS_PD_DIR)) nxt_st.regs.pd_dir = PWDATA[7:0];
					// pin-level and latch writes both land in the latch
					if (gpde_hit(PADDR, GPDE_OFS_PD_LAT) || gpde_hit(PADDR, GPDE_OFS_PD_PIN)) begin
						nxt_st.regs.pd_lat = PWDATA[7:0];
					end
					if (gpde_hit(PADDR, GPDE_OFS_PD_ANS)) nxt_st.regs.pd_ans = PWDATA[7:0];
					if (gpde_hit(PADDR, GPDE_OFS_PE_DIR)) nxt_st.regs.pe_dir = PWDATA[2:0];
					if (gpde_hit(PADDR, GPDE_OFS_PE_LAT) || gpde_hit(PADDR, GPDE_OFS_PE_PIN)) begin
						nxt_st.regs.pe_lat = PWDATA[2:0];
					end
					if (gpde_hit(PADDR, GPDE_OFS_PE_ANS)) nxt_st.regs.pe_ans = PWDATA[2:0];
					if (gpde_hit(PADDR, GPDE_OFS_SLEW))   nxt_st.regs.slew = PWDATA[4:0];
					if (gpde_hit(PADDR, GPDE_OFS_CFG3H)) begin
						nxt_st.regs.cfg = PWDATA[7:0] & GPDE_CFG3H_MASK;
					end
				end
			end
			default: begin
				nxt_st.bus.apb = GPDE_APB_IDLE;
			end
		endcase

		// port E pins 0..2: direction alone owns the driver, analog or not
		for (int i = 0; i < 3; i++) begin
			nxt_st.pads.pe_oe[i]  = !st_ff.regs.pe_dir[i];
			nxt_st.pads.pe_out[i] = st_ff.regs.pe_lat[i] & !st_ff.regs.pe_dir[i];
		end
		// pin 3 has no driver at all; it is either port bit or reset input
		nxt_st.pads.ext_rst_n = st_ff.regs.cfg[GPDE_CFG_RST_PIN] ? pe_sync[3] : 1'b1;

		// pin six: pwm C, then serial, then latch; analog select ignored
		if (PWM1_OUTPUT_C_EN && !st_ff.regs.pd_dir[GPDE_PD_SIX]) begin
			nxt_st.pads.pd_oe[0]  = 1'b1;
			nxt_st.pads.pd_out[0] = PWM1_OUTPUT_C;
		end else if (SERIAL2_EN && !SERIAL2_SYNC_MODE) begin
			nxt_st.pads.pd_oe[0]  = 1'b1;
			nxt_st.pads.pd_out[0] = SERIAL2_ASYNC_TX;
		end else if (SERIAL2_EN) begin
			nxt_st.pads.pd_oe[0]  = SERIAL2_SYNC_CLOCK_DRIVE;
			nxt_st.pads.pd_out[0] = SERIAL2_SYNC_CLOCK_OUT & SERIAL2_SYNC_CLOCK_DRIVE;
		end else begin
			nxt_st.pads.pd_oe[0]  = !st_ff.regs.pd_dir[GPDE_PD_SIX];
			nxt_st.pads.pd_out[0] = st_ff.regs.pd_lat[GPDE_PD_SIX] & !st_ff.regs.pd_dir[GPDE_PD_SIX];
		end

		// pin seven: pwm D, then serial data, async receive never drives
		if (PWM1_OUTPUT_D_EN && !st_ff.regs.pd_dir[GPDE_PD_SEVEN]) begin
			nxt_st.pads.pd_oe[1]  = 1'b1;
			nxt_st.pads.pd_out[1] = PWM1_OUTPUT_D;
		end else if (SERIAL2_EN && SERIAL2_SYNC_MODE) begin
			nxt_st.pads.pd_oe[1]  = SERIAL2_SYNC_DATA_DRIVE;
			nxt_st.pads.pd_out[1] = SERIAL2_SYNC_DATA_OUT & SERIAL2_SYNC_DATA_DRIVE;
		end else if (SERIAL2_EN) begin
			nxt_st.pads.pd_oe[1]  = 1'b0;
			nxt_st.pads.pd_out[1] = 1'b0;
		end else begin
			nxt_st.pads.pd_oe[1]  = !st_ff.regs.pd_dir[GPDE_PD_SEVEN];
			nxt_st.pads.pd_out[1] = st_ff.regs.pd_lat[GPDE_PD_SEVEN] & !st_ff.regs.pd_dir[GPDE_PD_SEVEN];
		end

		// receive data and clock in go through the digital input buffer
		nxt_st.pads.ser_rx  = pd_level[GPDE_PD_SEVEN];
		nxt_st.pads.ser_clk = pd_level[GPDE_PD_SIX];
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// reset constants set analog on port E pins 0..2 at power-on
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_ff <= GPDE_STATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// outputs, all straight from flops
	// ****************************************************************
	assign PRDATA              = st_ff.bus.prdata;
	assign PREADY              = st_ff.bus.apb[1];
	assign PSLVERR             = st_ff.bus.pslverr;
	assign PD_PIN_OUT          = st_ff.pads.pd_out;
	assign PD_PIN_OE           = st_ff.pads.pd_oe;
	assign PE_PIN_OUT          = st_ff.pads.pe_out;
	assign PE_PIN_OE           = st_ff.pads.pe_oe;
	assign SERIAL2_RX_DATA_IN  = st_ff.pads.ser_rx;
	assign SERIAL2_SYNC_CLOCK_IN = st_ff.pads.ser_clk;
	assign EXTERNAL_RESET_IN_N = st_ff.pads.ext_rst_n;
	assign ANALOG_SEL_D        = st_ff.regs.pd_ans[7:6];
	assign ANALOG_SEL_E        = st_ff.regs.pe_ans;
	assign SLEW_CTRL           = st_ff.regs.slew;
	// set bit means the function stays on its default pin
	assign PIN_MAP_CFG = {st_ff.regs.cfg[GPDE_CFG_PWM2B_MAP], st_ff.regs.cfg[GPDE_CFG_T3CK_MAP],
		st_ff.regs.cfg[GPDE_CFG_CC3_MAP], st_ff.regs.cfg[GPDE_CFG_CC2_MAP]};

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	sequence s_rd_access(logic [7:0] ofs);
		PSEL && PENABLE && !PWRITE && !PREADY && (PADDR == ofs);
	endsequence

	sequence s_wr_commit(logic [7:0] ofs);
		PSEL && PENABLE && PWRITE && PREADY && (PADDR == ofs);
	endsequence

	a_pe_dir_off: assert property (
		1'b1 |=> ((PE_PIN_OE & $past(st_ff.regs.pe_dir)) == 3'h0))
		else $error("port E driver on while direction is input");
	a_pe_drive_latch: assert property (
		1'b1 |=> (PE_PIN_OE == ~$past(st_ff.regs.pe_dir))
			&& (PE_PIN_OUT == ($past(st_ff.regs.pe_lat) & PE_PIN_OE)))
		else $error("port E output does not follow latch and direction");
	a_pe_analog_zero: assert property (
		s_rd_access(GPDE_OFS_PE_PIN) |=> PREADY
			&& ((PRDATA[2:0] & $past(st_ff.regs.pe_ans)) == 3'h0))
		else $error("analog port E pin read nonzero");
	a_latch_readback: assert property (
		s_rd_access(GPDE_OFS_PD_LAT) |=> PREADY && (PRDATA == {24'h0, $past(st_ff.regs.pd_lat)}))
		else $error("latch read did not return latch");
	a_reset_pin_sel: assert property (
		1'b1 |=> EXTERNAL_RESET_IN_N
			== ($past(st_ff.regs.cfg[GPDE_CFG_RST_PIN]) ? $past(pe_sync[3]) : 1'b1))
		else $error("reset pin function wrong");
	a_pd_analog_zero: assert property (
		s_rd_access(GPDE_OFS_PD_PIN) |=> ((PRDATA[7:6] & $past(st_ff.regs.pd_ans[7:6])) == 2'h0)
			&& (PRDATA[5:0] == 6'h00))
		else $error("analog port D pin read nonzero");
	a_tx_drive: assert property (
		(SERIAL2_EN && !SERIAL2_SYNC_MODE && !(PWM1_OUTPUT_C_EN && !st_ff.regs.pd_dir[6]))
			|=> PD_PIN_OE[0] && (PD_PIN_OUT[0] == $past(SERIAL2_ASYNC_TX)))
		else $error("async transmit not on pin six");
	a_pwm_drive: assert property (
		(PWM1_OUTPUT_D_EN && !st_ff.regs.pd_dir[7])
			|=> PD_PIN_OE[1] && (PD_PIN_OUT[1] == $past(PWM1_OUTPUT_D)))
		else $error("pwm D not on pin seven");
	a_pin_write_latch: assert property (
		s_wr_commit(GPDE_OFS_PE_PIN) |=> (st_ff.regs.pe_lat == $past(PWDATA[2:0])) && !PREADY)
		else $error("pin-level write missed the latch");
	a_unimpl_zero: assert property (
		s_rd_access(GPDE_OFS_PE_DIR) |=> PREADY && (PRDATA[31:3] == 29'h0) && !PSLVERR)
		else $error("unimplemented bits read nonzero");

endmodule : gpde_top

/* gpde_pins.sv */
/*
 * gpde_pins: the pad wires of port D pins 6/7 and port E outside the chip.
 * Assumes the bench sets the outside levels; the chip wins where it drives.
 */
`timescale 1ns/1ns
module gpde_pins
	import gpde_pkg::*;
(
	input  wire logic [1:0] pd_out,
	input  wire logic [1:0] pd_oe,
	input  wire logic [2:0] pe_out,
	input  wire logic [2:0] pe_oe,
	input  wire logic [1:0] ext_d,
	input  wire logic [3:0] ext_e,
	output logic      [1:0] pd_in,
	output logic      [3:0] pe_in
);
	// ****************************************************************
	// wire resolution
	// ****************************************************************
	// driven pad shows the chip value, else the outside level, which the
	// bench keeps defined so no unknown gets settled by chance
	assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_d);
	// pin three has no driver at all, always the outside level
	assign pe_in = {ext_e[3], (pe_oe & pe_out) | (~pe_oe & ext_e[2:0])};
endmodule : gpde_pins

/* tb_gpio_ports_d_e_pin_logic.sv */
/*
 * tb_gpio_ports_d_e_pin_logic: register, pad and takeover tests.
 * Assumes gpde_top with APB answering after one wait state.
 */
`timescale 1ns/1ns
module tb_gpio_ports_d_e_pin_logic
	import gpde_pkg::*;
;
	logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  pd_in, pd_out, pd_oe, ext_d, ans_d;
	logic [3:0]  pe_in, ext_e, pmap;
	logic [2:0]  pe_out, pe_oe, ans_e;
	logic [4:0]  slew;
	logic        pwm_c_en, pwm_c, pwm_d_en, pwm_d, s_en, s_sync, s_tx, s_ck;
	logic        s_ckdrv, s_dt, s_dtdrv, rx_in, ck_in, xrst_n;
	int          errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [31:0] rst_tab [10] = '{32'hFF, 32'h0, 32'h0, 32'hFF, 32'h7, 32'h0, 32'h0,
		32'h7, 32'h1F, 32'hBF};

	gpde_top dut (
		.REF_CLK(ref_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PD_PIN_IN(pd_in), .PD_PIN_OUT(pd_out),
		.PD_PIN_OE(pd_oe), .PE_PIN_IN(pe_in), .PE_PIN_OUT(pe_out), .PE_PIN_OE(pe_oe),
		.PWM1_OUTPUT_C_EN(pwm_c_en), .PWM1_OUTPUT_C(pwm_c), .PWM1_OUTPUT_D_EN(pwm_d_en),
		.PWM1_OUTPUT_D(pwm_d), .SERIAL2_EN(s_en), .SERIAL2_SYNC_MODE(s_sync),
		.SERIAL2_ASYNC_TX(s_tx), .SERIAL2_SYNC_CLOCK_OUT(s_ck),
		.SERIAL2_SYNC_CLOCK_DRIVE(s_ckdrv), .SERIAL2_SYNC_DATA_OUT(s_dt),
		.SERIAL2_SYNC_DATA_DRIVE(s_dtdrv), .SERIAL2_RX_DATA_IN(rx_in),
		.SERIAL2_SYNC_CLOCK_IN(ck_in), .EXTERNAL_RESET_IN_N(xrst_n),
		.ANALOG_SEL_D(ans_d), .ANALOG_SEL_E(ans_e), .SLEW_CTRL(slew), .PIN_MAP_CFG(pmap)
	);

	gpde_pins pins (
		.pd_out(pd_out), .pd_oe(pd_oe), .pe_out(pe_out), .pe_oe(pe_oe),
		.ext_d(ext_d), .ext_e(ext_e), .pd_in(pd_in), .pe_in(pe_in)
	);

	// ****************************************************************
	// clock, watchdog and tasks
	// ****************************************************************
	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// one APB transfer, then an idle cycle so no signal is driven twice per step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk(32'(err), 32'h0, "write error flag");
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read data");
	endtask : rchk

	// pads lag one edge, synced levels three; four covers both
	task automatic settle();
		repeat (4) @(posedge ref_clk);
	endtask : settle

	task automatic pdchk(input logic [1:0] oe, input logic [1:0] o);
		settle();
		chk(32'(pd_oe), 32'(oe), "pd enable");
		chk(32'(pd_out & oe), 32'(o), "pd value");
	endtask : pdchk

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pwm_c_en, pwm_c, pwm_d_en, pwm_d} = '0;
		{s_en, s_sync, s_tx, s_ck, s_ckdrv, s_dt, s_dtdrv} = '0;
		ext_d = 2'h0;
		ext_e = 4'hA;
		reset_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		// reset state: every pin input, analog on, map bits set
		for (int i = 0; i < 10; i++) begin
			rchk(8'(4 * i), rst_tab[i]);
		end
		chk(32'({pd_oe, pe_oe}), 32'h0, "enables");
		chk(32'({ans_d, ans_e}), 32'h1F, "analog select");
		chk(32'(pmap), 32'hF, "pin map");
		chk(32'(xrst_n), 32'h1, "ext reset");
		$display("test reset_values done");
		// refused: unaligned write must not land, unmapped read gives 0
		apb(1'b1, 8'h11, 32'h0);
		chk(32'(err), 32'h1, "unaligned error");
		apb(1'b0, 8'h28, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000, "unmapped error");
		rchk(GPDE_OFS_PE_DIR, 32'h7);
		wr(GPDE_OFS_SLEW, 32'hFFFF_FFEA);
		rchk(GPDE_OFS_SLEW, 32'h0A);
		chk(32'(slew), 32'h0A, "slew control");
		$display("test bus_errors done");
		// port E: pins 0/2 drive, pin 1 reads a low outside level
		ext_e <= 4'h0;
		wr(GPDE_OFS_PE_ANS, 32'h0);
		wr(GPDE_OFS_PE_LAT, 32'h7);
		wr(GPDE_OFS_PE_DIR, 32'h2);
		settle();
		chk(32'(pe_oe), 32'h5, "pe enable");
		chk(32'(pe_out & 3'h5), 32'h5, "pe value");
		rchk(GPDE_OFS_PE_LAT, 32'h7);
		rchk(GPDE_OFS_PE_PIN, 32'h5);
		wr(GPDE_OFS_PE_ANS, 32'hFFFF_FFFF);
		rchk(GPDE_OFS_PE_ANS, 32'h7);
		settle();
		chk(32'(pe_oe), 32'h5, "pe enable analog");
		rchk(GPDE_OFS_PE_PIN, 32'h0);
		wr(GPDE_OFS_PE_PIN, 32'h0);
		rchk(GPDE_OFS_PE_LAT, 32'h0);
		settle();
		chk(32'(pe_out & 3'h5), 32'h0, "pe value low");
		wr(GPDE_OFS_PE_DIR, 32'h7);
		$display("test port_e done");
		// pin three: reset role while enabled, plain input otherwise
		settle();
		chk(32'(xrst_n), 32'h0, "ext reset low");
		wr(GPDE_OFS_CFG3H, 32'h6E);
		rchk(GPDE_OFS_CFG3H, 32'h2E);
		settle();
		chk(32'(xrst_n), 32'h1, "ext reset off");
		chk(32'(pmap), 32'hA, "pin map");
		ext_e <= 4'h8;
		settle();
		rchk(GPDE_OFS_PE_PIN, 32'h8);
		chk(32'(pe_oe), 32'h0, "pe idle");
		$display("test input_only done");
		// port D 6/7: latch drive unaffected by analog; input gated by it
		wr(GPDE_OFS_PD_ANS, 32'h0);
		wr(GPDE_OFS_PD_LAT, 32'hC0);
		wr(GPDE_OFS_PD_DIR, 32'h3F);
		pdchk(2'h3, 2'h3);
		wr(GPDE_OFS_PD_ANS, 32'hC0);
		pdchk(2'h3, 2'h3);
		chk(32'(ans_d), 32'h3, "analog d");
		ext_d <= 2'h2;
		wr(GPDE_OFS_PD_DIR, 32'hFF);
		pdchk(2'h0, 2'h0);
		rchk(GPDE_OFS_PD_PIN, 32'h0);
		chk(32'(rx_in), 32'h0, "rx gated");
		wr(GPDE_OFS_PD_ANS, 32'h0);
		settle();
		rchk(GPDE_OFS_PD_PIN, 32'h80);
		chk(32'({rx_in, ck_in}), 32'h2, "serial inputs");
		$display("test port_d done");
		// serial over pins set as input, then PWM above serial once the pins are set as output
		s_en <= 1'b1;
		pdchk(2'h1, 2'h0);
		s_sync <= 1'b1;
		{s_ckdrv, s_ck, s_dtdrv} <= 3'h7;
		pdchk(2'h3, 2'h1);
		{s_ckdrv, s_dtdrv} <= 2'h0;
		ext_d <= 2'h1;
		pdchk(2'h0, 2'h0);
		chk(32'({rx_in, ck_in}), 32'h1, "serial sync inputs");
		{pwm_c_en, pwm_d_en} <= 2'h3;
		pdchk(2'h0, 2'h0);
		{s_ckdrv, s_dtdrv, s_dt} <= 3'h7;
		wr(GPDE_OFS_PD_DIR, 32'h3F);
		pdchk(2'h3, 2'h0);
		wr(GPDE_OFS_PD_ANS, 32'hC0);
		pwm_c <= 1'b1;
		pdchk(2'h3, 2'h1);
		$display("test takeover done");
		complete_run();
	end
endmodule : tb_gpio_ports_d_e_pin_logic
